// [gpio_port.sv]
// twelve-pin general-purpose port with debounce, event latches and interrupt line
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
// Functional notes
// - each pin's behaviour follows its own function-select field
// - plain input shows pin level in input-level bit, unaffected by inversion
// - per-pin optional debounce with selectable time, run from 32 kHz tick
// - rising and falling events latch per pin and stay set
// - independent pull enables; both set means bus keeper
// - bus keeper active on every pin after reset
// - plain output level set by write-only output-level bit, reads zero
// - inversion applies to outputs except functions 0x000 and 0x002
// - push-pull or open-drain select; ignored for 0x000, 0x002 always push-pull
// - per-pin drive-strength select bit
// - direction at bit 31 resets to input; alt and dsp functions override
// - read-only level register at 0x0C00, pin 1 at bit 0, reset 0
// - interrupt-status level views at 0x180B8 and 0x180D0 for plain inputs
// - per-event trigger type, 0 level 1 edge, reset 0, at 0x18238/0x18250
// - pins 9 to 12 latches at 0x18050 bits 15:8, rising even
// - mask bits sit 0x100 above latches; 1 blocks from interrupt line
// - all masks reset to 1 except boot-complete mask resets to 0
// - latches clear only on write of 1; line holds until all unmasked latches cleared
// - interrupt is OR of unmasked latches; masked still set and readable
// - pins 1 to 8 latches at 0x18038 bits 31:16, rising even
// - function 0x002 hands the pin to the dsp path
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int SLOW_DIV_P = SLOW_DIV
)(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // register port
  input wire logic [17:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // pins
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pull_up_enable,
  output logic [NUM_PINS-1:0] pull_down_enable,
  output logic [NUM_PINS-1:0] bus_keeper_enable,
  output logic [NUM_PINS-1:0] drive_strength_select,
  // alternate and dsp pin paths
  input wire logic [NUM_PINS-1:0] alt_out,
  input wire logic [NUM_PINS-1:0] alt_oe,
  input wire logic [NUM_PINS-1:0] dsp_out,
  input wire logic [NUM_PINS-1:0] dsp_oe,
  output logic [NUM_PINS-1:0] dsp_pin_path_in,
  // boot-complete event and interrupt
  input wire logic boot_complete_event,
  output logic interrupt_line_one
);

  logic [31:0] ctrl_q [NUM_PINS];
  logic [NUM_PINS-1:0] output_level_q;
  logic [NUM_PINS-1:0] level_q;
  logic [NUM_PINS-1:0] level_prev_q;
  logic [NUM_PINS-1:0] raw_q;
  logic [NUM_PINS-1:0] rise_latch_q;
  logic [NUM_PINS-1:0] fall_latch_q;
  logic [NUM_PINS-1:0] rise_type_q;
  logic [NUM_PINS-1:0] fall_type_q;
  logic [NUM_PINS-1:0] rise_mask_q;
  logic [NUM_PINS-1:0] fall_mask_q;
  logic boot_latch_q;
  logic boot_mask_q;
  logic [NUM_PINS-1:0] tick_seen_q;
  logic [15:0] div_q;
  logic slow_tick_q;
  logic [NUM_PINS-1:0] rise_set;
  logic [NUM_PINS-1:0] fall_set;
  logic [NUM_PINS-1:0] w1c_rise;
  logic [NUM_PINS-1:0] w1c_fall;

  function automatic logic [4:0] ctrl_index(input logic [17:0] a);
    logic [17:0] d;
    d = a - ADDR_CTRL_FIRST;
    if (a >= ADDR_CTRL_FIRST && a <= ADDR_CTRL_LAST && d[1:0] == 2'b00)
      ctrl_index = {1'b0, d[5:2]};
    else
      ctrl_index = 5'h1F;
  endfunction

  // place per-pin bits into the low-pin and high-pin register words
  function automatic logic [31:0] pack_pairs(input logic [NUM_PINS-1:0] r,
      input logic [NUM_PINS-1:0] f, input logic hi);
    logic [31:0] w;
    w = 32'h00000000;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (!hi && i < LO_PINS)
      begin
        w[LO_BASE + 2 * i] = r[i];
        w[LO_BASE + 2 * i + 1] = f[i];
      end
      if (hi && i >= LO_PINS)
      begin
        w[HI_BASE + 2 * (i - LO_PINS)] = r[i];
        w[HI_BASE + 2 * (i - LO_PINS) + 1] = f[i];
      end
    end
    pack_pairs = w;
  endfunction

  function automatic logic pair_bit(input logic [31:0] w, input int i, input logic fall);
    if (i < LO_PINS)
      pair_bit = w[LO_BASE + 2 * i + int'(fall)];
    else
      pair_bit = w[HI_BASE + 2 * (i - LO_PINS) + int'(fall)];
  endfunction

  // slow debounce tick divided from the main clock
  always_ff @(posedge clock)
  begin
    if (srst || div_q == 16'(SLOW_DIV_P - 1))
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      slow_tick_q <= 1'b0;
    else
      slow_tick_q <= (div_q == 16'(SLOW_DIV_P - 1));
  end

  // control registers; output level bit kept apart and never read back
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (srst)
      begin
        ctrl_q[i] <= CTRL_RESET;
        output_level_q[i] <= 1'b0;
      end
      else if (reg_we && ctrl_index(reg_addr) == 5'(i))
      begin
        ctrl_q[i] <= reg_wdata & CTRL_RW_MASK & ~(32'h1 << F_LVL);
        output_level_q[i] <= reg_wdata[F_LVL];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : pin_g
      logic [9:0] fn;
      logic [DB_CNT_W-1:0] cnt_q;
      logic [DB_CNT_W-1:0] limit;
      assign fn = ctrl_q[g][9:0];
      // ticks of the slow clock: microseconds times rate, rounded up
      assign limit = DB_CNT_W'((DB_US[ctrl_q[g][F_DBT_LO +: 4]] * 64'(SLOW_HZ)
        + 64'd999999) / 64'd1000000);

      always_ff @(posedge clock)
      begin
        if (srst)
        begin
          raw_q[g] <= 1'b0;
          cnt_q <= '0;
          level_q[g] <= 1'b0;
        end
        else
        begin
          raw_q[g] <= pin_in[g];
          if (!ctrl_q[g][F_DB])
          begin
            level_q[g] <= raw_q[g];
            cnt_q <= '0;
          end
          else if (raw_q[g] == level_q[g])
            cnt_q <= '0;
          else if (slow_tick_q)
          begin
            if (cnt_q + 1'b1 >= limit)
            begin
              level_q[g] <= raw_q[g];
              cnt_q <= '0;
            end
            else
              cnt_q <= cnt_q + 1'b1;
          end
        end
      end

      // pin driver: alternate, plain logic or dsp path per function
      always_ff @(posedge clock)
      begin
        if (srst)
        begin
          pin_out[g] <= 1'b0;
          pin_oe[g] <= 1'b0;
          dsp_pin_path_in[g] <= 1'b0;
        end
        else
        begin
          dsp_pin_path_in[g] <= (fn == FN_DSP) ? raw_q[g] : 1'b0;
          case (fn)
            FN_ALT:
            begin
              pin_out[g] <= alt_out[g];
              pin_oe[g] <= alt_oe[g];
            end
            FN_DSP:
            begin
              pin_out[g] <= dsp_out[g];
              pin_oe[g] <= dsp_oe[g];
            end
            FN_LOGIC:
            begin
              logic v;
              v = output_level_q[g] ^ ctrl_q[g][F_POL];
              pin_out[g] <= ctrl_q[g][F_OD] ? 1'b0 : v;
              pin_oe[g] <= !ctrl_q[g][F_DIR] && (!ctrl_q[g][F_OD] || !v);
            end
            default:
            begin
              pin_out[g] <= 1'b0;
              pin_oe[g] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (srst)
      begin
        pull_up_enable[i] <= 1'b1;
        pull_down_enable[i] <= 1'b1;
        bus_keeper_enable[i] <= 1'b1;
        drive_strength_select[i] <= 1'b1;
      end
      else
      begin
        pull_up_enable[i] <= ctrl_q[i][F_PU] && !ctrl_q[i][F_PD];
        pull_down_enable[i] <= ctrl_q[i][F_PD] && !ctrl_q[i][F_PU];
        bus_keeper_enable[i] <= ctrl_q[i][F_PU] && ctrl_q[i][F_PD];
        drive_strength_select[i] <= ctrl_q[i][F_DRV];
      end
    end
  end

  // event detection: edge on level change, level re-asserts each slow tick
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      level_prev_q <= '0;
      tick_seen_q <= '0;
    end
    else
    begin
      level_prev_q <= level_q;
      tick_seen_q <= {NUM_PINS{slow_tick_q}};
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      rise_set[i] = rise_type_q[i] ? (level_q[i] && !level_prev_q[i])
        : (level_q[i] && tick_seen_q[i]);
      fall_set[i] = fall_type_q[i] ? (!level_q[i] && level_prev_q[i])
        : (!level_q[i] && tick_seen_q[i]);
      w1c_rise[i] = reg_we && pair_bit(reg_wdata, i, 1'b0)
        && reg_addr == (i < LO_PINS ? ADDR_LATCH_LO : ADDR_LATCH_HI);
      w1c_fall[i] = reg_we && pair_bit(reg_wdata, i, 1'b1)
        && reg_addr == (i < LO_PINS ? ADDR_LATCH_LO : ADDR_LATCH_HI);
    end
  end

  // latches: set wins over a simultaneous write-one clear
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rise_latch_q <= '0;
      fall_latch_q <= '0;
      boot_latch_q <= 1'b0;
    end
    else
    begin
      rise_latch_q <= rise_set | (rise_latch_q & ~w1c_rise);
      fall_latch_q <= fall_set | (fall_latch_q & ~w1c_fall);
      boot_latch_q <= boot_complete_event || (boot_latch_q
        && !(reg_we && reg_addr == ADDR_BOOT_LATCH && reg_wdata[BOOT_BIT]));
    end
  end

  // trigger types and masks
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rise_type_q <= '0;
      fall_type_q <= '0;
      rise_mask_q <= '1;
      fall_mask_q <= '1;
      boot_mask_q <= 1'b0;
    end
    else if (reg_we)
    begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
        if (reg_addr == (i < LO_PINS ? ADDR_TYPE_LO : ADDR_TYPE_HI))
        begin
          rise_type_q[i] <= pair_bit(reg_wdata, i, 1'b0);
          fall_type_q[i] <= pair_bit(reg_wdata, i, 1'b1);
        end
        if (reg_addr == (i < LO_PINS ? ADDR_LATCH_LO : ADDR_LATCH_HI) + ADDR_MASK_OFFSET)
        begin
          rise_mask_q[i] <= pair_bit(reg_wdata, i, 1'b0);
          fall_mask_q[i] <= pair_bit(reg_wdata, i, 1'b1);
        end
      end
      if (reg_addr == ADDR_BOOT_LATCH + ADDR_MASK_OFFSET)
        boot_mask_q <= reg_wdata[BOOT_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      interrupt_line_one <= 1'b0;
    else
      interrupt_line_one <= |(rise_latch_q & ~rise_mask_q) | |(fall_latch_q & ~fall_mask_q)
        | (boot_latch_q & ~boot_mask_q);
  end

  // read data one cycle after the read strobe
  always_ff @(posedge clock)
  begin
    logic [NUM_PINS-1:0] plain_in;
    logic [4:0] idx;
    plain_in = '0;
    idx = ctrl_index(reg_addr);
    for (int i = 0; i < NUM_PINS; i++)
      plain_in[i] = level_q[i] && ctrl_q[i][9:0] == FN_LOGIC && ctrl_q[i][F_DIR];
    if (srst || !reg_re)
      reg_rdata <= 32'h00000000;
    else if (reg_addr == ADDR_LEVELS)
      reg_rdata <= {20'h00000, level_q};
    else if (idx != 5'h1F)
      reg_rdata <= ctrl_q[idx[3:0]];
    else if (reg_addr == ADDR_VIEW_LO || reg_addr == ADDR_VIEW_HI)
      reg_rdata <= pack_pairs(plain_in, '0, reg_addr == ADDR_VIEW_HI);
    else if (reg_addr == ADDR_LATCH_LO || reg_addr == ADDR_LATCH_HI)
      reg_rdata <= pack_pairs(rise_latch_q, fall_latch_q, reg_addr == ADDR_LATCH_HI);
    else if (reg_addr == ADDR_TYPE_LO || reg_addr == ADDR_TYPE_HI)
      reg_rdata <= pack_pairs(rise_type_q, fall_type_q, reg_addr == ADDR_TYPE_HI);
    else if (reg_addr == ADDR_LATCH_LO + ADDR_MASK_OFFSET
        || reg_addr == ADDR_LATCH_HI + ADDR_MASK_OFFSET)
      reg_rdata <= pack_pairs(rise_mask_q, fall_mask_q,
        reg_addr == ADDR_LATCH_HI + ADDR_MASK_OFFSET);
    else if (reg_addr == ADDR_BOOT_LATCH)
      reg_rdata <= 32'(boot_latch_q) << BOOT_BIT;
    else if (reg_addr == ADDR_BOOT_LATCH + ADDR_MASK_OFFSET)
      reg_rdata <= 32'(boot_mask_q) << BOOT_BIT;
    else
      reg_rdata <= 32'h00000000;
  end

  property p_latch_hold;
    @(posedge clock) disable iff (srst)
      rise_latch_q[0] && !w1c_rise[0] |=> rise_latch_q[0];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch lost");

  property p_irq_or;
    @(posedge clock) disable iff (srst)
      (fall_latch_q[0] && !fall_mask_q[0]) |=> interrupt_line_one;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not raised");

  property p_masked_quiet;
    @(posedge clock) disable iff (srst)
      (rise_mask_q == '1 && fall_mask_q == '1 && (boot_mask_q || !boot_latch_q))
        |=> !interrupt_line_one;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked irq");

  property p_edge_rise;
    @(posedge clock) disable iff (srst)
      rise_type_q[0] && $rose(level_q[0]) |=> rise_latch_q[0];
  endproperty
  a_edge_rise: assert property (p_edge_rise) else $error("rise missed");

  property p_edge_fall;
    @(posedge clock) disable iff (srst)
      fall_type_q[0] && $fell(level_q[0]) |=> fall_latch_q[0];
  endproperty
  a_edge_fall: assert property (p_edge_fall) else $error("fall missed");

  property p_level_retrig;
    @(posedge clock) disable iff (srst)
      !rise_type_q[0] && level_q[0] && tick_seen_q[0] |=> rise_latch_q[0];
  endproperty
  a_level_retrig: assert property (p_level_retrig) else $error("no retrigger");

  property p_db_hold;
    @(posedge clock) disable iff (srst)
      ctrl_q[3][F_DB] && !slow_tick_q |=> $stable(level_q[3]);
  endproperty
  a_db_hold: assert property (p_db_hold) else $error("debounce leaked");

  property p_dsp_drive;
    @(posedge clock) disable iff (srst)
      ctrl_q[4][9:0] == FN_DSP |=> pin_oe[4] == $past(dsp_oe[4]);
  endproperty
  a_dsp_drive: assert property (p_dsp_drive) else $error("dsp path wrong");

endmodule

// [gpio_port_pkg.sv]
// register map, field positions, reset values and timing constants of the pin port
package gpio_port_pkg;
  localparam int NUM_PINS = 12;
  localparam logic [17:0] ADDR_LEVELS = 18'h00C00;
  localparam logic [17:0] ADDR_CTRL_FIRST = 18'h00C08;
  localparam logic [17:0] ADDR_CTRL_LAST = 18'h00C34;
  localparam logic [17:0] ADDR_LATCH_LO = 18'h18038;
  localparam logic [17:0] ADDR_LATCH_HI = 18'h18050;
  localparam logic [17:0] ADDR_BOOT_LATCH = 18'h18014;
  localparam logic [17:0] ADDR_MASK_OFFSET = 18'h00100;
  localparam logic [17:0] ADDR_VIEW_LO = 18'h180B8;
  localparam logic [17:0] ADDR_VIEW_HI = 18'h180D0;
  localparam logic [17:0] ADDR_TYPE_LO = 18'h18238;
  localparam logic [17:0] ADDR_TYPE_HI = 18'h18250;
  localparam logic [17:0] ADDR_MASK_FIRST = 18'h18110;
  localparam logic [17:0] ADDR_MASK_LAST = 18'h18154;
  localparam int LO_PINS = 8;
  localparam int LO_BASE = 16;
  localparam int HI_BASE = 8;
  localparam int BOOT_BIT = 3;
  localparam int MASK_WORDS = 18;
  localparam int F_DIR = 31;
  localparam int F_PU = 30;
  localparam int F_PD = 29;
  localparam int F_DRV = 24;
  localparam int F_DBT_LO = 16;
  localparam int F_LVL = 15;
  localparam int F_OD = 14;
  localparam int F_DB = 13;
  localparam int F_POL = 12;
  localparam logic [31:0] CTRL_RESET = 32'hE1000001;
  localparam logic [31:0] CTRL_RW_MASK = 32'hE10F73FF;
  localparam logic [9:0] FN_ALT = 10'h000;
  localparam logic [9:0] FN_LOGIC = 10'h001;
  localparam logic [9:0] FN_DSP = 10'h002;
  localparam int CLK_HZ = 25000000;
  localparam int SLOW_HZ = 32768;
  localparam int SLOW_DIV = (CLK_HZ + SLOW_HZ / 2) / SLOW_HZ;
  // debounce times in microseconds: 100us, 1.5ms, 3ms, then doubling up to 768ms, which entries 10 to 15 all hold
  localparam int DB_US [0:15] = '{100, 1500, 3000, 6000, 12000, 24000, 48000, 96000,
    192000, 384000, 768000, 768000, 768000, 768000, 768000, 768000};
  localparam int DB_CNT_W = 15;
endpackage

// [pin_partner.sv]
// pin-side model: external drivers, pulls and keeper resolving each pin level
`timescale 1ns/100ps
module pin_partner
  import gpio_port_pkg::*;
(
  // clock
  input wire logic clock,
  // device side
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] pull_up_enable,
  input wire logic [NUM_PINS-1:0] pull_down_enable,
  input wire logic [NUM_PINS-1:0] bus_keeper_enable,
  // external buttons and logic
  input wire logic [NUM_PINS-1:0] ext_level,
  input wire logic [NUM_PINS-1:0] ext_en,
  output logic [NUM_PINS-1:0] pin_level
);
  logic [NUM_PINS-1:0] last_q;

  // device driver wins, then the external part, then keeper or pulls
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (pin_oe[i])
        pin_level[i] = pin_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_level[i];
      else if (bus_keeper_enable[i])
        pin_level[i] = last_q[i];
      else if (pull_up_enable[i])
        pin_level[i] = 1'b1;
      else if (pull_down_enable[i])
        pin_level[i] = 1'b0;
      else
        pin_level[i] = ~last_q[i];
    end
  end

  // floating pins toggle so a stale level is never mistaken for a driven one
  always_ff @(posedge clock)
    last_q <= pin_level;
endmodule

// [tb.sv]
// self-checking bench for the twelve-pin port
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
  import gpio_port_pkg::*;
  typedef struct {logic [17:0] a; logic [31:0] m; logic [31:0] e;} row_t;
  typedef struct {logic [31:0] c; logic o; logic oe;} out_row_t;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [17:0] reg_addr = 18'h00000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic [NUM_PINS-1:0] pin_level, pin_out, pin_oe, pu, pd, keep, drv, dsp_in;
  logic [NUM_PINS-1:0] ext_level = 12'h000;
  logic [NUM_PINS-1:0] ext_en = 12'hFFF;
  logic [NUM_PINS-1:0] side_out = 12'hFFF;
  logic [NUM_PINS-1:0] side_oe = 12'hFFF;
  logic boot = 1'b0;
  logic irq;
  logic [31:0] d;
  int failures = 0;
  int checks = 0;
  row_t rows [10] = '{'{ADDR_CTRL_FIRST, 32'hFFFFFFFF, CTRL_RESET},
    '{ADDR_CTRL_LAST, 32'hFFFFFFFF, CTRL_RESET}, '{ADDR_LEVELS, 32'h00000FFF, 32'h0},
    '{18'h18138, 32'hFFFF0000, 32'hFFFF0000}, '{18'h18150, 32'h0000FF00, 32'h0000FF00},
    '{18'h18114, 32'h00000008, 32'h0}, '{ADDR_TYPE_LO, 32'hFFFF0000, 32'h0},
    '{ADDR_TYPE_HI, 32'h0000FF00, 32'h0}, '{ADDR_VIEW_LO, 32'h55550000, 32'h0},
    '{18'h00004, 32'hFFFFFFFF, 32'h0}};
  out_row_t outs [6] = '{'{32'h61008001, 1'b1, 1'b1}, '{32'h61009001, 1'b0, 1'b1},
    '{32'h6100C001, 1'b1, 1'b0}, '{32'h61004001, 1'b0, 1'b1},
    '{32'h6000D002, 1'b1, 1'b1}, '{32'h60001000, 1'b1, 1'b1}};

  always #20 clock = ~clock;

  gpio_port #(.SLOW_DIV_P(4)) dut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_enable(pu),
    .pull_down_enable(pd), .bus_keeper_enable(keep), .drive_strength_select(drv),
    .alt_out(side_out), .alt_oe(side_oe), .dsp_out(side_out), .dsp_oe(side_oe),
    .dsp_pin_path_in(dsp_in), .boot_complete_event(boot), .interrupt_line_one(irq));

  pin_partner far (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_enable(pu), .pull_down_enable(pd), .bus_keeper_enable(keep),
    .ext_level(ext_level), .ext_en(ext_en), .pin_level(pin_level));

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a);
    @(posedge clock);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    // read data stand until the next edge; sample them there
    @(posedge clock);
    d = reg_rdata;
  endtask

  // event word image: rising on even bit, falling on the odd bit above it
  function automatic logic [31:0] lat(input logic [NUM_PINS-1:0] p, input bit hi,
    input bit f);
    lat = 32'h0;
    for (int n = 0; n < NUM_PINS; n++)
      if ((n >= LO_PINS) == hi)
        lat[(hi ? HI_BASE + 2 * (n - LO_PINS) : LO_BASE + 2 * n) + f] = p[n];
  endfunction

  task automatic check_rows();
    foreach (rows[i])
    begin
      rd(rows[i].a);
      `CHK(d & rows[i].m, rows[i].e)
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #800000;
    failures++;
    summarize();
  end

  initial
  begin
    wait_cyc(20);
    srst <= 1'b0;
    check_rows();
    `CHK({keep, drv, pin_oe}, {12'hFFF, 12'hFFF, 12'h000})
    // pin levels with pin 1 inverted
    wr(ADDR_CTRL_FIRST, CTRL_RESET | 32'h00001000);
    ext_level <= 12'hA5D;
    wait_cyc(6);
    rd(ADDR_LEVELS);
    `CHK(d[11:0], 12'hA5D)
    rd(ADDR_VIEW_LO);
    `CHK(d & 32'h55550000, lat(12'hA5D, 1'b0, 1'b0))
    rd(ADDR_VIEW_HI);
    `CHK(d & 32'h00005500, lat(12'hA5D, 1'b1, 1'b0))
    // edge events latch and hold
    wr(ADDR_TYPE_LO, 32'hFFFF0000);
    wr(ADDR_TYPE_HI, 32'h0000FF00);
    wr(ADDR_LATCH_LO, 32'hFFFFFFFF);
    wr(ADDR_LATCH_HI, 32'hFFFFFFFF);
    rd(ADDR_LATCH_LO);
    `CHK(d[31:16], 16'h0)
    ext_level <= 12'h000;
    wait_cyc(26);
    rd(ADDR_LATCH_LO);
    `CHK(d & 32'hFFFF0000, lat(12'hA5D, 1'b0, 1'b1))
    rd(ADDR_LATCH_HI);
    `CHK(d & 32'h0000FF00, lat(12'hA5D, 1'b1, 1'b1))
    // masking and interrupt line
    `CHK(irq, 1'b0)
    wr(18'h18138, 32'hFFFDFFFF);
    wait_cyc(3);
    `CHK(irq, 1'b1)
    wr(ADDR_LATCH_LO, 32'h00200000);
    wait_cyc(3);
    `CHK(irq, 1'b1)
    wr(ADDR_LATCH_LO, 32'h00020000);
    wait_cyc(3);
    `CHK(irq, 1'b0)
    boot <= 1'b1;
    @(posedge clock);
    boot <= 1'b0;
    wait_cyc(3);
    `CHK(irq, 1'b1)
    wr(ADDR_BOOT_LATCH, 32'h00000008);
    wait_cyc(3);
    `CHK(irq, 1'b0)
    wr(18'h18138, 32'hFFFFFFFF);
    // level type re-sets, edge type stays cleared
    wr(ADDR_TYPE_LO, 32'hFFFB0000);
    ext_level <= 12'h003;
    wait_cyc(6);
    wr(ADDR_LATCH_LO, 32'h00050000);
    wait_cyc(12);
    rd(ADDR_LATCH_LO);
    `CHK({d[18], d[16]}, 2'b10)
    // output modes on pin 3
    foreach (outs[i])
    begin
      wr(ADDR_CTRL_FIRST + 18'h00008, outs[i].c);
      wait_cyc(3);
      `CHK(pin_oe[2], outs[i].oe)
      if (outs[i].oe)
        `CHK(pin_out[2], outs[i].o)
    end
    `CHK(drv[2], 1'b0)
    wr(ADDR_CTRL_FIRST + 18'h00008, 32'h61008001);
    rd(ADDR_CTRL_FIRST + 18'h00008);
    `CHK(d, 32'h61000001)
    // dsp input path on pin 5
    side_oe <= 12'h000;
    wr(ADDR_CTRL_FIRST + 18'h00010, 32'hE1000002);
    ext_level <= 12'h010;
    wait_cyc(4);
    `CHK(dsp_in[4], 1'b1)
    // debounce on pin 4
    wr(ADDR_CTRL_FIRST + 18'h0000C, 32'hE1002001);
    ext_level <= 12'h000;
    wait_cyc(40);
    ext_level <= 12'h008;
    wait_cyc(4);
    ext_level <= 12'h000;
    wait_cyc(30);
    rd(ADDR_LEVELS);
    `CHK(d[3], 1'b0)
    ext_level <= 12'h008;
    wait_cyc(8);
    rd(ADDR_LEVELS);
    `CHK(d[3], 1'b0)
    wait_cyc(40);
    rd(ADDR_LEVELS);
    `CHK(d[3], 1'b1)
    // pull-up alone on pin 6
    wr(ADDR_CTRL_FIRST + 18'h00014, 32'hC1000001);
    wait_cyc(3);
    `CHK({pu[5], pd[5], keep[5]}, 3'b100)
    // second reset in mid-run
    ext_level <= 12'h000;
    srst <= 1'b1;
    wait_cyc(3);
    srst <= 1'b0;
    check_rows();
    summarize();
  end
endmodule
